// ### bac_top.v
`include "bac_defines.vh"

// Function
// [R1] One cell per bit, two half-cells.
// [R2] Each cell starts by inverting prior level.
// [R3] Second half toggles for 1, holds for 0.
// [R4] Preambles violate coding; receiver finds framing there.
// [R5] Sub-frame: 4-bit preamble plus 28 data bits.
// [R6] Frames are two sub-frames, channels alternating.
// [R7] Control value one enables the receive decoder.
// [R8] Control value D: transmit on, divisor 24.
// [R9] Sub-frame spans 64 half-cells, 56 for data.
// [R10] Receive at 32 kHz needs 16.384 MHz reference.
// [R11] Transmit at 32 kHz needs 49.152 MHz reference.
// [R12] Word: audio 27..4, validity, user, status, preamble.
// [R13] Preamble codes 0001 block, 0010, 0011 channels.
// [R14] Bit 31 is even parity above preamble.
// [R15] Underrun sends null sub-frames with validity set.
module bac_top (
  // Clock and reset.
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // Control register value.
  input  wire [31:0] ctrl_reg_i,
  // Transmit stream slave.
  input  wire [31:0] s_axis_tdata_i,
  input  wire        s_axis_tvalid_i,
  output wire        s_axis_tready_o,
  // Receive stream master.
  output reg  [31:0] m_axis_tdata_o,
  output reg         m_axis_tvalid_o,
  output reg         m_axis_tid_o,
  input  wire        m_axis_tready_i,
  // Serial lines.
  input  wire        line_i,
  output reg         line_o,
  // Status pulses.
  output reg         tx_underrun_o,
  output reg         rx_err_o,
  output reg         rx_overrun_o
);

  // ****************************************************************
  // Control decode.
  // ****************************************************************
  // Bit 0 enables both directions; bits 5..2 pick the bit-period divisor,
  // eight clocks per step, so a field of 3 gives a divisor of 24. [R8]
  wire       en_w     = ctrl_reg_i[`BAC_CTRL_EN_BIT];
  wire [3:0] cfg_w    = ctrl_reg_i[`BAC_CFG_MSB:`BAC_CFG_LSB];
  wire [3:0] cfg_eff  = (cfg_w == 4'h0) ? 4'h1 : cfg_w;   // Zero would stall the line.
  wire [7:0] half_cyc = cfg_eff * `BAC_HALF_UNIT;          // Half of a bit period. [R1]

  // ****************************************************************
  // Transmit state.
  // ****************************************************************
  reg [7:0]  tick_r;      // Clocks into the current half-cell.
  reg [5:0]  hc_r;        // Half-cell index within the sub-frame.
  reg [31:0] sh_r;        // Sub-frame being sent.
  reg [7:0]  pat_r;       // Preamble pattern of that sub-frame.
  reg        pinv_r;      // Line level before the preamble.
  reg        chan_r;      // Channel of the sub-frame being sent.
  reg [7:0]  frm_r;       // Frame index within the audio block.
  reg [31:0] hold_r;      // One-word hand-over buffer.
  reg        hold_vld_r;  // Buffer holds a word.
  reg        tready_r;    // Registered ready toward the stream.

  wire       tick     = (tick_r == half_cyc - 8'h01);
  wire       last     = tick && (hc_r == `BAC_HALF_LAST);
  wire       take     = s_axis_tvalid_i && tready_r;
  wire       use_hold = last && hold_vld_r;
  wire       hold_nxt = take || (hold_vld_r && !use_hold);
  wire [5:0] hc_nxt   = hc_r + 6'h01;      // Half-cell that the next tick starts.
  wire       dbit     = sh_r[hc_nxt[5:1]]; // Bits 4..31 follow the preamble.

  assign s_axis_tready_o = tready_r;

  // ****************************************************************
  // Next sub-frame selection.
  // ****************************************************************
  reg [31:0] nw_nxt;      // Next word with parity rebuilt.
  reg [3:0]  ncode_nxt;   // Its preamble code.
  reg [7:0]  npat_nxt;    // Its line pattern.
  reg        line_nxt;    // Next line level.

  // A word from the buffer keeps its own preamble code; without one, a null
  // sub-frame continues the channel and block sequence so the remote stays
  // locked. Parity is always recomputed, so a bad source word cannot break it.
  always @* begin
    nw_nxt = 32'h00000000;
    if (hold_vld_r) begin
      nw_nxt = hold_r;
    end else begin
      nw_nxt[`BAC_W_VALID] = 1'b1;                          // Null sample. [R15]
      if (!chan_r) begin
        nw_nxt[`BAC_W_PRE_MSB:0] = `BAC_PRE_CH1;            // [R6]
      end else if (frm_r == `BAC_BLK_FRAMES - 8'h01) begin
        nw_nxt[`BAC_W_PRE_MSB:0] = `BAC_PRE_BLOCK;
      end else begin
        nw_nxt[`BAC_W_PRE_MSB:0] = `BAC_PRE_CH0;
      end
    end
    nw_nxt[`BAC_W_PARITY] = ^nw_nxt[30:`BAC_W_DATA_LSB];    // [R12] [R14]
    ncode_nxt = nw_nxt[`BAC_W_PRE_MSB:0];
    case (ncode_nxt)
      `BAC_PRE_BLOCK: npat_nxt = `BAC_PAT_BLOCK;            // [R13]
      `BAC_PRE_CH1:   npat_nxt = `BAC_PAT_CH1;
      default:        npat_nxt = `BAC_PAT_CH0;
    endcase
  end

  // Line level for the next half-cell. It is decoded from the index of that
  // half-cell, not the current one, or every cell would slip by one half.
  always @* begin
    if (hc_nxt < `BAC_PRE_HALVES) begin
      // Preamble: fixed pattern, inverted after a high line. [R4]
      line_nxt = pat_r[3'h7 - hc_nxt[2:0]] ^ pinv_r;
    end else if (!hc_nxt[0]) begin
      line_nxt = ~line_o;               // Cell start inverts. [R2]
    end else begin
      line_nxt = line_o ^ dbit;         // Toggle for 1, hold for 0. [R3]
    end
  end

  // ****************************************************************
  // Transmit sequencer.
  // ****************************************************************
  // The half-cell counter wraps every 64 half-cells, one sub-frame. [R9]
  // While disabled it parks on the last half-cell so that the first tick
  // after enabling loads a sub-frame at once.
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_r        <= 8'h00;
      hc_r          <= `BAC_HALF_LAST;
      sh_r          <= 32'h00000000;
      pat_r         <= 8'h00;
      pinv_r        <= 1'b0;
      chan_r        <= 1'b1;
      frm_r         <= 8'h00;
      line_o        <= 1'b0;
      tx_underrun_o <= 1'b0;
    end else if (!en_w) begin
      tick_r        <= 8'h00;
      hc_r          <= `BAC_HALF_LAST;
      line_o        <= 1'b0;
      pinv_r        <= 1'b0;
      tx_underrun_o <= 1'b0;
    end else begin
      tx_underrun_o <= last && !hold_vld_r;
      tick_r        <= tick ? 8'h00 : tick_r + 8'h01;
      if (tick) begin
        hc_r <= hc_nxt;
        if (hc_r != `BAC_HALF_LAST) begin
          line_o <= line_nxt;
        end else begin
          // First half-cell of the new preamble, inverted from the end of
          // the last cell; that end level is remembered to orient the pattern.
          sh_r   <= nw_nxt;
          pat_r  <= npat_nxt;
          pinv_r <= line_o;
          line_o <= npat_nxt[7] ^ line_o;
          chan_r <= (ncode_nxt == `BAC_PRE_CH1);            // [R6]
          if (ncode_nxt == `BAC_PRE_BLOCK) begin
            frm_r <= 8'h00;
          end else if (ncode_nxt != `BAC_PRE_CH1) begin
            frm_r <= (frm_r == `BAC_BLK_FRAMES - 8'h01) ? 8'h00 : frm_r + 8'h01;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Transmit hand-over buffer.
  // ****************************************************************
  // Ready is the registered inverse of the buffer state, so a word is never
  // taken into a full buffer; the source stalls until a sub-frame starts.
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_r     <= 32'h00000000;
      hold_vld_r <= 1'b0;
      tready_r   <= 1'b0;
    end else begin
      if (take) begin
        hold_r <= s_axis_tdata_i;
      end
      hold_vld_r <= hold_nxt;
      tready_r   <= en_w && !hold_nxt;
    end
  end

  // ****************************************************************
  // Receive path.
  // ****************************************************************
  wire [31:0] rx_word;    // Assembled sub-frame.
  wire        rx_stb;     // One-cycle strobe with the word.
  wire        rx_err;     // Coding, framing or parity fault.

  bac_rx_dec u_rx (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .enable_i   (en_w),
    .half_cyc_i (half_cyc),
    .line_i     (line_i),
    .word_o     (rx_word),
    .word_stb_o (rx_stb),
    .err_o      (rx_err)
  );

  // Stream master. There is no queue: a word not accepted before the next
  // sub-frame ends is replaced and an overrun pulse is raised.
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      m_axis_tdata_o  <= 32'h00000000;
      m_axis_tvalid_o <= 1'b0;
      m_axis_tid_o    <= 1'b0;
      rx_err_o        <= 1'b0;
      rx_overrun_o    <= 1'b0;
    end else begin
      rx_err_o     <= rx_err;
      rx_overrun_o <= rx_stb && m_axis_tvalid_o && !m_axis_tready_i;
      if (rx_stb) begin
        m_axis_tdata_o  <= rx_word;
        m_axis_tvalid_o <= 1'b1;
        // Channel 1 only for its own code; block start is channel 0. [R6]
        m_axis_tid_o    <= (rx_word[`BAC_W_PRE_MSB:0] == `BAC_PRE_CH1);
      end else if (m_axis_tready_i || !en_w) begin
        m_axis_tvalid_o <= 1'b0;
      end
    end
  end

endmodule

// ### bac_defines.vh
`ifndef BAC_DEFINES_VH
`define BAC_DEFINES_VH

// ****************************************************************
// Control word layout.
// ****************************************************************
`define BAC_CTRL_EN_BIT   0
`define BAC_CFG_LSB       2
`define BAC_CFG_MSB       5
// Sys clocks per half-cell for each step of the clock configuration field.
`define BAC_HALF_UNIT     8'h04

// ****************************************************************
// Stream word layout.
// ****************************************************************
`define BAC_W_PARITY      31
`define BAC_W_VALID       28
`define BAC_W_DATA_LSB    4
`define BAC_W_PRE_MSB     3
`define BAC_PRE_BLOCK     4'h1
`define BAC_PRE_CH0       4'h2
`define BAC_PRE_CH1       4'h3

// ****************************************************************
// Line patterns, given for a line that was low before the preamble.
// ****************************************************************
`define BAC_PAT_BLOCK     8'he8
`define BAC_PAT_CH0       8'he2
`define BAC_PAT_CH1       8'he4
`define BAC_HALF_LAST     6'h3f
`define BAC_PRE_HALVES    6'h08
`define BAC_BLK_FRAMES    8'hc0

`endif

// ### bac_rx_dec.v
`include "bac_defines.vh"

// Receive decoder: measures the time between line transitions in half-cells,
// rebuilds the half-cell stream, finds preambles by their coding violation
// and assembles 32-bit stream words.
module bac_rx_dec (
  // Clock and reset.
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // Control.
  input  wire        enable_i,
  input  wire [7:0]  half_cyc_i,
  // Serial line, asynchronous to the clock.
  input  wire        line_i,
  // Word output.
  output reg  [31:0] word_o,
  output reg         word_stb_o,
  output reg         err_o
);

  // ****************************************************************
  // Input synchroniser and interval measurement.
  // ****************************************************************
  reg        sync1_r;     // First stage, read only by the second.
  reg        sync2_r;     // Second stage.
  reg        lvl_r;       // Previous synchronised level.
  reg [9:0]  cnt_r;       // Cycles since the last transition.
  reg [1:0]  pend_r;      // Half-cells still to be pushed.
  reg        plvl_r;      // Level of the half-cells being pushed.
  reg        lock_r;      // A preamble was found and framing holds.
  reg [5:0]  pos_r;       // Half-cell index within the sub-frame.
  reg [7:0]  pre_r;       // Collected preamble half-cells.
  reg        h0_r;        // First half of the current data cell.
  reg        lh_r;        // Last half-cell pushed.
  reg [27:0] dat_r;       // Data bits, first received at the bottom.
  reg [3:0]  code_r;      // Decoded preamble code.

  wire       edge_w = sync2_r ^ lvl_r;
  wire [9:0] cnt2   = {cnt_r[8:0], 1'b0};
  wire [9:0] h3     = {2'b00, half_cyc_i} * 10'h003;
  wire [9:0] h5     = {2'b00, half_cyc_i} * 10'h005;
  wire [9:0] h7     = {2'b00, half_cyc_i} * 10'h007;
  // Interval length in half-cells: 1, 2, 3, or 0 for a run of three and a half half-cells or more.
  wire [1:0] nhalf  = (cnt2 < h3) ? 2'd1 : (cnt2 < h5) ? 2'd2 : (cnt2 < h7) ? 2'd3 : 2'd0;
  // Preamble normalised to a line that was low before it.
  wire [7:0] raw    = {pre_r[6:0], plvl_r};
  wire [7:0] pat    = raw[7] ? raw : ~raw;
  wire       bitv   = h0_r ^ plvl_r;   // Two transitions in a cell mean a 1. [R3]
  wire [31:0] wfull = {bitv, dat_r[27:1], code_r};

  // Synchroniser and transition timing. Intervals are sized from the same
  // half-cell figure as the transmitter, so the remote rate must match it.
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      lvl_r   <= 1'b0;
      cnt_r   <= 10'h000;
    end else begin
      sync1_r <= line_i;
      sync2_r <= sync1_r;
      lvl_r   <= sync2_r;
      if (edge_w || !enable_i) begin
        cnt_r <= 10'h001;
      end else if (cnt_r != 10'h3ff) begin
        cnt_r <= cnt_r + 10'h001;
      end
    end
  end

  // Half-cell push and framing. Interval ends load the pending count; one
  // half-cell is consumed per clock, so a half-cell must span at least two clocks.
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r     <= 2'd0;
      plvl_r     <= 1'b0;
      lock_r     <= 1'b0;
      pos_r      <= 6'h00;
      pre_r      <= 8'h00;
      h0_r       <= 1'b0;
      lh_r       <= 1'b0;
      dat_r      <= 28'h0000000;
      code_r     <= 4'h0;
      word_o     <= 32'h00000000;
      word_stb_o <= 1'b0;
      err_o      <= 1'b0;
    end else begin
      word_stb_o <= 1'b0;
      err_o      <= 1'b0;
      if (!enable_i) begin
        // Decoder held idle until the enable bit is set. [R7]
        lock_r <= 1'b0;
        pend_r <= 2'd0;
      end else if (edge_w) begin
        plvl_r <= lvl_r;
        pend_r <= nhalf;
        if (nhalf == 2'd0) begin
          // Interval longer than any legal length: framing is lost.
          lock_r <= 1'b0;
          err_o  <= lock_r;
        end else if (nhalf == 2'd3 && (!lock_r || pos_r >= `BAC_PRE_HALVES)) begin
          // Only a preamble holds a three-half run; it restarts framing. [R4]
          err_o  <= lock_r && (pos_r != 6'h00);
          lock_r <= 1'b1;
          pos_r  <= 6'h00;
        end
      end else if (cnt_r == 10'h3ff) begin
        lock_r <= 1'b0;
      end else if (pend_r != 2'd0) begin
        pend_r <= pend_r - 2'd1;
        lh_r   <= plvl_r;
        if (lock_r) begin
          pos_r <= pos_r + 6'h01;
          if (pos_r < `BAC_PRE_HALVES) begin
            pre_r <= raw;
            if (pos_r == `BAC_PRE_HALVES - 6'h01) begin
              // Preamble pattern names block start and channel. [R13]
              if (pat == `BAC_PAT_BLOCK) begin
                code_r <= `BAC_PRE_BLOCK;
              end else if (pat == `BAC_PAT_CH0) begin
                code_r <= `BAC_PRE_CH0;
              end else if (pat == `BAC_PAT_CH1) begin
                code_r <= `BAC_PRE_CH1;
              end else begin
                lock_r <= 1'b0;
                err_o  <= 1'b1;
              end
            end
          end else if (!pos_r[0]) begin
            h0_r <= plvl_r;
            // Each cell must start with a transition. [R2]
            if (plvl_r == lh_r) begin
              lock_r <= 1'b0;
              err_o  <= 1'b1;
            end
          end else begin
            dat_r <= {bitv, dat_r[27:1]};
            if (pos_r == `BAC_HALF_LAST) begin
              // Sub-frame complete: 28 data bits over a 4-bit code. [R5] [R9]
              word_o     <= wfull;
              word_stb_o <= 1'b1;
              err_o      <= ^wfull[31:4];   // Even parity check. [R14]
            end
          end
        end
      end
    end
  end

endmodule

// ### bac_top_monitor.sv
// ****************
// Line and stream checks.
// ****************
module bac_top_monitor (
  // Clock and reset.
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  // Control and streams.
  input wire logic [31:0] ctrl_reg_i,
  input wire logic        s_axis_tvalid_i,
  input wire logic        s_axis_tready_o,
  input wire logic [31:0] m_axis_tdata_o,
  input wire logic        m_axis_tvalid_o,
  input wire logic        m_axis_tid_o,
  input wire logic        m_axis_tready_i,
  // Serial output.
  input wire logic        line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire        en   = ctrl_reg_i[0];  // Enable bit.
  wire  [3:0] cfg  = ctrl_reg_i[5:2];  // Clock configuration field.
  // A zero field is taken as one, so the half-cell never collapses.
  wire  [7:0] half = (cfg == 4'h0) ? 8'h04 : {2'h0, cfg, 2'h0};
  logic [7:0] run_r;   // Clocks since the last line change.
  logic       seen_r;  // A change was seen while enabled.
  logic       prev_r;  // Line level one clock earlier.
  // Counts the stand time of each line level; cleared while disabled.
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_r  <= 8'h00;
      seen_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      prev_r <= line_o;
      if (!en) begin
        run_r  <= 8'h00;
        seen_r <= 1'b0;
      end else if (line_o != prev_r) begin
        run_r  <= 8'h00;
        seen_r <= 1'b1;
      end else if (run_r != 8'hff) begin
        run_r  <= run_r + 8'h01;
      end
    end
  end
  half_hold_a: assert property (en && seen_r && line_o != prev_r |->
    run_r == half - 8'h01 || run_r == 8'h02 * half - 8'h01 || run_r == 8'h03 * half - 8'h01)
    else $error("line level did not stand whole half-cells");
  cell_run_a: assert property (en && seen_r |-> run_r < 8'h03 * half)
    else $error("line held longer than three half-cells");
  line_off_a: assert property (!en ##1 !en |-> !line_o)
    else $error("line driven while disabled");
  ready_take_a: assert property (s_axis_tvalid_i && s_axis_tready_o |=> !s_axis_tready_o)
    else $error("ready stayed high after a take");
  ready_off_a: assert property (!en |=> !s_axis_tready_o)
    else $error("ready high while disabled");
  rx_hold_a: assert property (m_axis_tvalid_o && !m_axis_tready_i && en |=> m_axis_tvalid_o)
    else $error("receive valid dropped without ready");
  rx_tid_a: assert property (m_axis_tvalid_o |-> m_axis_tid_o == (m_axis_tdata_o[3:0] == 4'h3))
    else $error("channel id does not match code");
  rx_code_a: assert property ($rose(m_axis_tvalid_o) |-> m_axis_tdata_o[3:0] inside {4'h1, 4'h2, 4'h3})
    else $error("receive word with unknown preamble code");
endmodule

bind bac_top bac_top_monitor i_mon (.sys_clk_i, .sys_rst_i, .ctrl_reg_i, .s_axis_tvalid_i, .s_axis_tready_o,
  .m_axis_tdata_o, .m_axis_tvalid_o, .m_axis_tid_o, .m_axis_tready_i, .line_o);

// ### bac_remote_model.sv
// ****************
// Remote device: loops the line back.
// ****************
module bac_remote_model (
  // Clock.
  input  wire logic sys_clk_i,
  // Line from the block, controls.
  input  wire logic tx_line_i,
  input  wire logic slow_i,
  input  wire logic flip_i,
  // Line to the block.
  output wire logic rx_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [19:0] dly_r = 20'h00000;  // Cable delay line.
  // Retransmits cells and preambles as received, so their coding is kept.
  always @(posedge sys_clk_i) begin
    dly_r <= {dly_r[18:0], tx_line_i};
  end
  // Slow mode adds a long lag; flip forces a coding fault on command.
  assign rx_line_o = (slow_i ? dly_r[19] : dly_r[0]) ^ flip_i;
endmodule

// ### bac_top_tb.sv
// ****************
// Loopback bench.
// ****************
module bac_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [31:0] ctrl_reg_i = 32'h0;
  logic [31:0] s_axis_tdata_i = 32'h0;
  logic        s_axis_tvalid_i = 1'b0;
  logic        m_axis_tready_i = 1'b0;
  logic        slow = 1'b0;  // Remote lag select.
  logic        flip = 1'b0;  // Remote fault select.
  logic        hold = 1'b0;  // Stalls the receive sink.
  logic        chk_en = 1'b0;  // Word checks on.
  wire  [31:0] m_axis_tdata_o;
  wire         s_axis_tready_o, m_axis_tvalid_o, m_axis_tid_o, line_i, line_o;
  wire         tx_underrun_o, rx_err_o, rx_overrun_o;
  int          bad_count = 0, cmp_count = 0, n_null = 0, n_und = 0, n_err = 0, n_ovr = 0;
  int          i, p;
  logic [31:0] exp_q[$];  // Words sent and not yet back.

  bac_top i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ctrl_reg_i(ctrl_reg_i),
    .s_axis_tdata_i(s_axis_tdata_i), .s_axis_tvalid_i(s_axis_tvalid_i), .s_axis_tready_o(s_axis_tready_o),
    .m_axis_tdata_o(m_axis_tdata_o), .m_axis_tvalid_o(m_axis_tvalid_o), .m_axis_tid_o(m_axis_tid_o),
    .m_axis_tready_i(m_axis_tready_i), .line_i(line_i), .line_o(line_o), .tx_underrun_o(tx_underrun_o),
    .rx_err_o(rx_err_o), .rx_overrun_o(rx_overrun_o));
  bac_remote_model i_remote (.sys_clk_i(sys_clk_i), .tx_line_i(line_o), .slow_i(slow), .flip_i(flip),
    .rx_line_o(line_i));

  // The bench clock stands in for the audio reference clock; rates are scaled.
  always #50 sys_clk_i = ~sys_clk_i;

  // Word as it should come back: parity recomputed even over bits 30:4.
  function automatic logic [31:0] exp_word(input logic [31:0] w);
    return {^w[30:4], w[30:4], w[3:0]};
  endfunction

  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    check32({31'h0, got}, {31'h0, exp}, msg);
  endtask

  // Offers one word and holds it until ready is seen at an edge.
  task automatic send_word(input logic [31:0] w);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    #1;
    s_axis_tdata_i = w;
    s_axis_tvalid_i = 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (s_axis_tready_o !== 1'b1 && n < 3000);
    check_bit(n < 3000, 1'b1, "send stalled");
    exp_q.push_back(exp_word(w));
    #1;
    s_axis_tvalid_i = 1'b0;
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Random sink stalls; the negedge below sees what the next edge takes.
  always @(posedge sys_clk_i) begin
    #1;
    m_axis_tready_i = !hold && ($urandom_range(3) != 0);
  end

  // Counts status pulses and checks each word taken while word checks are on.
  always @(negedge sys_clk_i) begin
    n_und += tx_underrun_o;
    n_err += rx_err_o;
    n_ovr += rx_overrun_o;
    if (chk_en && m_axis_tvalid_o && m_axis_tready_i) begin
      if (m_axis_tdata_o[30:4] === 27'h1000000) begin
        n_null++;
        check_bit(m_axis_tdata_o[31], 1'b1, "null parity");
      end else if (exp_q.size() == 0) begin
        check_bit(1'b0, 1'b1, "unexpected word");
      end else begin
        check32(m_axis_tdata_o, exp_q.pop_front(), "rx word");
        check_bit(m_axis_tid_o, m_axis_tdata_o[3:0] == 4'h3, "channel id");
      end
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    bad_count++;
    $display("BAD %0t: watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    void'($urandom(32'hbf9bed3b));
    repeat (16) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    // Divisor 24 with a short lag, then the smallest divisor with a long lag.
    for (p = 0; p < 2; p++) begin
      @(posedge sys_clk_i);
      #1;
      ctrl_reg_i = p ? 32'h00000001 : 32'h0000000d;
      slow = p[0];
      chk_en = 1'b1;
      n_null = 0;
      n_und = 0;
      n_err = 0;
      repeat (2304) @(posedge sys_clk_i);
      for (i = 0; i < 6; i++) begin
        logic [31:0] w;
        w = $urandom;
        w[31] = 1'b0;
        w[3:0] = (i == 0) ? 4'h1 : (i[0] ? 4'h3 : 4'h2);
        if (w[30:4] == 27'h1000000)
          w[4] = 1'b1;
        send_word(w);
      end
      repeat (3072) @(posedge sys_clk_i);
      check_bit(exp_q.size() == 0, 1'b1, "all words back");
      check_bit(n_null > 0 && n_und > 0, 1'b1, "null sub-frames");
      check_bit(n_err == 0, 1'b1, "clean line");
      @(posedge sys_clk_i);
      #1;
      ctrl_reg_i = 32'h0;
      // Long enough for the remote's cable delay to drain before re-enabling.
      repeat (24) @(posedge sys_clk_i);
      check_bit(line_o, 1'b0, "line idle");
      $display("pass %0d done", p);
    end
    // Sink stalls over several sub-frames of null words.
    @(posedge sys_clk_i);
    #1;
    ctrl_reg_i = 32'h0000000d;
    hold = 1'b1;
    n_ovr = 0;
    repeat (4608) @(posedge sys_clk_i);
    hold = 1'b0;
    repeat (800) @(posedge sys_clk_i);
    check_bit(n_ovr > 0, 1'b1, "overrun pulse");
    $display("overrun test done");
    // One half-cell inverted on the wire in mid sub-frame.
    chk_en = 1'b0;
    repeat ($urandom_range(767)) @(posedge sys_clk_i);
    #1;
    n_err = 0;
    flip = 1'b1;
    repeat (12) @(posedge sys_clk_i);
    #1;
    flip = 1'b0;
    repeat (1600) @(posedge sys_clk_i);
    check_bit(n_err > 0, 1'b1, "coding fault seen");
    $display("fault test done");
    report_and_stop;
  end
endmodule
